// file: rtl/host_pkg.sv
// Shared constants and types of the serial register-port host controller.
package host_pkg;

  localparam int unsigned CLK_MHZ     = 100;
  // Half periods of the host-made link clocks, in nanoseconds.
  localparam int unsigned I2C_HALF_NS = 1250;
  localparam int unsigned SPI_HALF_NS = 80;
  // Least half periods round up so the clock never runs above its rate.
  localparam int unsigned I2C_HALF_CYC = (I2C_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SPI_HALF_CYC = (SPI_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W        = 8;

  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [2:0]  LAST_BIT   = 3'h7;
  localparam logic [7:0]  ONE_LEFT   = 8'h01;
  localparam logic [7:0]  IDLE_BYTE  = 8'hff;

  localparam logic [7:0]  RESET_CODE  = 8'h7a;
  localparam logic [7:0]  SETPTR_CODE = 8'h7d;
  localparam logic        RW_READ     = 1'b1;
  localparam logic        RW_WRITE    = 1'b0;

  typedef enum logic [2:0] {
    OP_RECV, OP_BWRITE, OP_BREAD, OP_SPI_RESET, OP_SPI_SETPTR, OP_SPI_WRITE, OP_SPI_READ
  } op_t;

  typedef enum logic [2:0] {S_IDLE, S_START, S_LOAD, S_BIT, S_ACK, S_RSTART, S_STOP} state_t;
  typedef enum logic [1:0] {P_DEV, P_REG, P_CMD, P_DATA} phase_t;

  typedef struct packed {
    op_t        op;
    logic       spi_3wire;
    logic [6:0] dev_addr;
    logic [7:0] reg_addr;
    logic [7:0] count;
  } cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rd_beat_t;

endpackage : host_pkg

// file: rtl/serial_host_register_port.sv
// Host controller driving the register port over I2C, 4-wire SPI or 3-wire SPI.
//
// Behaviour
// - Receive byte: start, address with read bit, one byte in, NACK, stop.
// - Block write: start, address with write bit, register, data bytes, stop.
// - Block read: register write, repeated start, read address, ACK all, NACK last.
// - Every SPI command and data unit is an 8-bit packet under chip select.
// - SPI data sampled on rising clock; clock and data idle high.
// - 4-wire SPI sends on master-out while reading master-in at once.
// - SPI write is the write code then one or more data bytes.
// - SPI read is the read code then eight clocks per wanted byte.
// - 3-wire SPI: host drives command byte, data byte driven per direction.
// - The device is selected only by its chip select driven low.
// - Several commands may follow while chip select stays low; this host raises chip select after each command.
`timescale 1ns/1ps

module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign out_data_o = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Ready and valid are registered from the next count so both flags are honest.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q        <= '0;
      rd_q        <= '0;
      cnt_q       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q       <= cnt_d;
      in_ready_o  <= (cnt_d != (AW + 1)'(DEPTH));
      out_valid_o <= (cnt_d != '0);
    end
  end
endmodule : byte_fifo

module serial_host_register_port #(
  parameter logic [7:0] WRITE_CODE = 8'h01,
  parameter logic [7:0] READ_CODE  = 8'h02
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  input  wire logic              cmd_valid_i,
  input  wire host_pkg::cmd_t    cmd_i,
  output logic                   cmd_ready_o,
  input  wire logic              deep_sleep_flag_i,
  input  wire logic              wr_valid_i,
  input  wire logic [7:0]        wr_data_i,
  output logic                   wr_ready_o,
  output host_pkg::rd_beat_t     rd_o,
  output logic                   done_o,
  output logic                   nack_o,
  output logic                   cs_b_o,
  output logic                   sck_o,
  output logic                   mosi_o,
  input  wire logic              miso_i,
  input  wire logic              shared_data_line_i,
  output logic                   shared_data_line_o,
  output logic                   shared_data_line_oe_o,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_o,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o
);
  import host_pkg::*;

  function automatic logic is_i2c(input op_t op);
    return (op == OP_RECV) || (op == OP_BWRITE) || (op == OP_BREAD);
  endfunction : is_i2c

  function automatic logic [7:0] spi_code(input op_t op);
    case (op)
      OP_SPI_RESET:  return RESET_CODE;
      OP_SPI_SETPTR: return SETPTR_CODE;
      OP_SPI_WRITE:  return WRITE_CODE;
      default:       return READ_CODE;
    endcase
  endfunction : spi_code

  // Pin inputs cross from the link into the system clock through two flops.
  logic [3:0] pin_raw;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  assign pin_raw = {scl_i, sda_i, shared_data_line_i, miso_i};

  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        sync1_q[g] <= 1'b1;
        sync2_q[g] <= 1'b1;
      end else begin
        sync1_q[g] <= pin_raw[g];
        sync2_q[g] <= sync1_q[g];
      end
    end
  end

  logic miso_s, sdl_s, sda_s, scl_s;
  assign {scl_s, sda_s, sdl_s, miso_s} = sync2_q;

  state_t     state_q;
  phase_t     ph_q;
  op_t        op_q;
  logic       spi3_q, rx_q, rw_q, half_q, use_fifo_q;
  logic [6:0] dev_q;
  logic [7:0] reg_q, fixed_q, n_q, sh_q;
  logic [2:0] bit_q;
  logic [TMR_W-1:0] tmr_q, half_len_q;

  logic       i2c, accept, tick, hold, din, ack_bad, byte_end, need_fifo;
  logic       fifo_valid, fifo_pop;
  logic [7:0] fifo_data, rx_byte, load_byte;

  assign i2c       = is_i2c(op_q);
  assign accept    = (state_q == S_IDLE) && cmd_valid_i && cmd_ready_o;
  assign tick      = (tmr_q == '0);
  // A slave holding the clock low stretches the high half.
  assign hold      = i2c && half_q && !scl_s &&
                     (state_q == S_BIT || state_q == S_ACK || state_q == S_STOP);
  assign din       = i2c ? sda_s : (spi3_q ? sdl_s : miso_s);
  assign rx_byte   = i2c ? sh_q : {sh_q[6:0], din};
  assign ack_bad   = !rx_q && sda_s;
  assign byte_end  = tick && half_q &&
                     ((state_q == S_BIT && bit_q == LAST_BIT && !i2c) ||
                      (state_q == S_ACK && !ack_bad));
  assign need_fifo = (ph_q == P_DATA) && !rx_q && use_fifo_q;
  assign fifo_pop  = (state_q == S_LOAD) && tick && need_fifo && fifo_valid;
  assign load_byte = (ph_q == P_REG) ? reg_q :
                     (rx_q ? IDLE_BYTE : (use_fifo_q ? fifo_data : fixed_q));

  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (wr_valid_i),
    .in_data_i   (wr_data_i),
    .in_ready_o  (wr_ready_o),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // Half-period timer; the host makes the link clock by this divider.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tmr_q      <= '0;
      half_len_q <= '0;
    end else if (accept) begin
      half_len_q <= is_i2c(cmd_i.op) ? TMR_W'(I2C_HALF_CYC - 1) : TMR_W'(SPI_HALF_CYC - 1);
      tmr_q      <= is_i2c(cmd_i.op) ? TMR_W'(I2C_HALF_CYC - 1) : TMR_W'(SPI_HALF_CYC - 1);
    end else if (state_q != S_IDLE && !hold) begin
      tmr_q <= tick ? half_len_q : tmr_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q     <= S_IDLE;
      ph_q        <= P_DEV;
      op_q        <= OP_RECV;
      {spi3_q, rx_q, rw_q, half_q, use_fifo_q} <= '0;
      dev_q       <= '0;
      reg_q       <= '0;
      fixed_q     <= '0;
      n_q         <= '0;
      sh_q        <= '0;
      bit_q       <= '0;
      cmd_ready_o <= 1'b1;
      rd_o        <= '0;
      done_o      <= 1'b0;
      nack_o      <= 1'b0;
    end else begin
      rd_o.valid <= 1'b0;
      done_o     <= 1'b0;
      nack_o     <= 1'b0;
      if (accept) begin
        op_q       <= cmd_i.op;
        spi3_q     <= cmd_i.spi_3wire;
        dev_q      <= cmd_i.dev_addr;
        reg_q      <= cmd_i.reg_addr;
        rw_q       <= (cmd_i.op == OP_RECV) ? RW_READ : RW_WRITE;
        use_fifo_q <= (cmd_i.op == OP_BWRITE) || (cmd_i.op == OP_SPI_WRITE);
        fixed_q    <= (cmd_i.op == OP_SPI_RESET) ? RESET_CODE : cmd_i.reg_addr;
        n_q        <= (cmd_i.op == OP_RECV || cmd_i.op == OP_SPI_RESET ||
                       cmd_i.op == OP_SPI_SETPTR) ? ONE_LEFT : cmd_i.count;
        half_q     <= 1'b0;
        if (cmd_i.op == OP_RECV && deep_sleep_flag_i) begin
          done_o <= 1'b1;
          nack_o <= 1'b1;
        end else begin
          cmd_ready_o <= 1'b0;
          state_q     <= S_START;
        end
      end else if (tick) begin
        case (state_q)
          S_START: begin
            half_q <= ~half_q;
            if (half_q) begin
              state_q <= S_BIT;
              bit_q   <= '0;
              rx_q    <= 1'b0;
              if (i2c) begin
                sh_q <= {dev_q, rw_q};
                ph_q <= P_DEV;
              end else begin
                sh_q <= spi_code(op_q);
                ph_q <= P_CMD;
              end
            end
          end
          S_LOAD: begin
            if (!need_fifo || fifo_valid) begin
              sh_q    <= load_byte;
              bit_q   <= '0;
              state_q <= S_BIT;
            end
          end
          S_BIT: begin
            half_q <= ~half_q;
            if (half_q) begin
              sh_q <= {sh_q[6:0], din};
              if (bit_q != LAST_BIT) begin
                bit_q <= bit_q + 1'b1;
              end else if (i2c) begin
                state_q <= S_ACK;
              end
            end
          end
          S_ACK: begin
            half_q <= ~half_q;
            if (half_q && ack_bad) begin
              nack_o  <= 1'b1;
              state_q <= S_STOP;
            end
          end
          S_RSTART: begin
            state_q <= S_START;
          end
          S_STOP: begin
            half_q <= ~half_q;
            if (half_q) begin
              state_q     <= S_IDLE;
              cmd_ready_o <= 1'b1;
              done_o      <= 1'b1;
            end
          end
          default: state_q <= S_IDLE;
        endcase
        if (byte_end) begin
          case (ph_q)
            P_DEV: begin
              ph_q    <= rw_q ? P_DATA : P_REG;
              rx_q    <= rw_q;
              state_q <= S_LOAD;
            end
            P_REG: begin
              if (op_q == OP_BREAD) begin
                rw_q    <= RW_READ;
                state_q <= S_RSTART;
              end else begin
                ph_q    <= P_DATA;
                state_q <= S_LOAD;
              end
            end
            P_CMD: begin
              ph_q    <= P_DATA;
              rx_q    <= (op_q == OP_SPI_READ);
              state_q <= S_LOAD;
            end
            default: begin
              if (rx_q) begin
                rd_o.valid <= 1'b1;
                rd_o.data  <= rx_byte;
              end
              n_q     <= n_q - 1'b1;
              state_q <= (n_q == ONE_LEFT) ? S_STOP : S_LOAD;
            end
          endcase
        end
      end
    end
  end

  // Pin levels; each pin is re-registered so outputs leave straight from flops.
  logic in_bit, spi_on, scl_low, sda_low;
  assign in_bit  = (state_q == S_BIT);
  // Each command gets its own select frame; chaining commands under one select is not used.
  assign spi_on  = !i2c && (state_q != S_IDLE);
  assign scl_low = i2c && ((((state_q == S_BIT) || (state_q == S_ACK) ||
                             (state_q == S_STOP)) && !half_q) ||
                           (state_q == S_LOAD) || (state_q == S_RSTART));
  // Reading, the host acknowledges every byte except the last.
  assign sda_low = i2c && (((state_q == S_START) && half_q) || (state_q == S_STOP) ||
                           (in_bit && !rx_q && !sh_q[7]) ||
                           ((state_q == S_ACK) && rx_q && (n_q != ONE_LEFT)));

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_b_o                <= 1'b1;
      sck_o                 <= 1'b1;
      mosi_o                <= 1'b1;
      shared_data_line_o    <= 1'b1;
      shared_data_line_oe_o <= 1'b0;
      scl_o                 <= 1'b0;
      scl_oe_o              <= 1'b0;
      sda_o                 <= 1'b0;
      sda_oe_o              <= 1'b0;
    end else begin
      cs_b_o                <= !spi_on;
      sck_o                 <= !(spi_on && in_bit) || half_q;
      mosi_o                <= !(spi_on && in_bit && !spi3_q && !rx_q) || sh_q[7];
      shared_data_line_o    <= sh_q[7];
      // Released for the whole read byte; the device turns the line by counting.
      shared_data_line_oe_o <= spi_on && in_bit && spi3_q && !rx_q;
      scl_o                 <= 1'b0;
      scl_oe_o              <= scl_low;
      sda_o                 <= 1'b0;
      sda_oe_o              <= sda_low;
    end
  end
endmodule : serial_host_register_port

// file: tb/register_port_device.sv
// Behavioural model of the register-port device on both serial buses.
`timescale 1ns/1ps
module register_port_device
  import host_pkg::*;
#(
  parameter logic [7:0] WRITE_CODE = 8'h01,
  parameter logic [7:0] READ_CODE  = 8'h02
) (
  input  wire logic cs_b_i,
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic three_wire_i,
  input  wire logic shl_i,
  output logic      miso_o,
  output logic      shl_o = 1'b1,
  output logic      shl_oe_o = 1'b0,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_low_o = 1'b0
);
  logic [7:0] regs [256];
  logic [7:0] ptr = 8'h00;
  logic [7:0] sh, ish;
  logic [7:0] last = 8'h00;
  // No timeout: a half-finished transfer simply waits for more clocks.
  logic [1:0] md = 2'h0;
  int         bc = 0, ib = 8, nb = -1;
  logic       rd = 1'b0, setp = 1'b0;
  initial foreach (regs[i]) regs[i] = 8'(i) ^ 8'h5a;
  // A deselected master-in line is left floating, so show the inverse of its last bit.
  assign miso_o = cs_b_i ? ~shl_o : shl_o;
  always @(negedge cs_b_i) begin
    bc = 0;
    md = 2'h0;
  end
  always @(posedge sck_i) if (!cs_b_i) begin
    sh = {sh[6:0], three_wire_i ? shl_i : mosi_i};
    bc = bc + 1;
    if (bc == 8) begin
      bc = 0;
      case (md)
        2'h0: begin
          if (sh == SETPTR_CODE) md = 2'h1;
          if (sh == WRITE_CODE) md = 2'h2;
          if (sh == READ_CODE) md = 2'h3;
          if (sh == RESET_CODE && last == RESET_CODE) sh = 8'h00;
        end
        2'h1: begin
          ptr = sh;
          md = 2'h0;
        end
        2'h2: begin
          regs[ptr] = sh;
          ptr = ptr + 8'h01;
        end
        default: ptr = ptr + 8'h01;
      endcase
      last = sh;
    end
  end
  // Data bits move on the falling edge so they are settled at the host's sample.
  always @(negedge sck_i or posedge cs_b_i) begin
    if (!cs_b_i) shl_o = regs[ptr][3'h7 - 3'(bc)];
    shl_oe_o = !cs_b_i && three_wire_i && md == 2'h3;
  end
  // The data line arrives delayed, so a change at a clock fall is not taken for start or stop.
  always @(negedge sda_i) if (scl_i) begin
    ib = 8;
    nb = -1;
    rd = 1'b0;
  end
  always @(posedge sda_i) if (scl_i) begin
    ib = 8;
    nb = -1;
    setp = 1'b0;
  end
  always @(posedge scl_i) begin
    if (ib < 8) ish = {ish[6:0], sda_i};
    else if (nb == 0) rd = ish[0];
    else if (nb > 0 && rd) begin
      if (setp) ptr = ptr + 8'h01;
      rd = !sda_i;
    end else if (nb == 1) begin
      ptr = ish;
      setp = 1'b1;
    end else if (nb > 1) begin
      regs[ptr] = ish;
      ptr = ptr + 8'h01;
    end
  end
  always @(negedge scl_i) begin
    ib = (ib == 8) ? 0 : ib + 1;
    if (ib == 0) nb = nb + 1;
    sda_low_o = (ib == 8) ? !(rd && nb > 0)
              : (rd && nb > 0 && !regs[ptr][3'h7 - 3'(ib)]);
  end
endmodule : register_port_device

// file: tb/serial_host_register_port_properties.sv
// Concurrent checks on the ports of the serial register-port host controller.
`timescale 1ns/1ps
module serial_host_register_port_properties
  import host_pkg::*;
(
  input wire logic               clk_sys_i,
  input wire logic               rst_b_i,
  input wire logic               cmd_valid_i,
  input wire host_pkg::cmd_t     cmd_i,
  input wire logic               cmd_ready_o,
  input wire logic               deep_sleep_flag_i,
  input wire host_pkg::rd_beat_t rd_o,
  input wire logic               done_o,
  input wire logic               nack_o,
  input wire logic               cs_b_o,
  input wire logic               sck_o,
  input wire logic               mosi_o,
  input wire logic               shared_data_line_oe_o,
  input wire logic               scl_oe_o,
  input wire logic               sda_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sequence take_s;
    cmd_valid_i && cmd_ready_o;
  endsequence
  sequence sleepy_recv_s;
    take_s ##0 (cmd_i.op == OP_RECV && deep_sleep_flag_i);
  endsequence
  sequence bus_take_s;
    take_s ##0 !(cmd_i.op == OP_RECV && deep_sleep_flag_i);
  endsequence
  sequence refused_s;
    done_o && nack_o && !sda_oe_o && !scl_oe_o && cmd_ready_o;
  endsequence
  sequence low_half_s;
    !sck_o [*8] ##1 sck_o;
  endsequence

  a_idle_lines_high: assert property (cs_b_o |-> sck_o && mosi_o)
    else $error("serial clock or data not high while deselected");
  a_sample_edge_stable: assert property ($rose(sck_o) |-> $stable(mosi_o))
    else $error("master-out changed on the sampling edge");
  a_clock_under_select: assert property (!sck_o |-> !cs_b_o)
    else $error("serial clock pulsed without chip select");
  a_low_half_length: assert property ($fell(sck_o) |-> low_half_s)
    else $error("serial clock low half of wrong length");
  a_busy_after_take: assert property (bus_take_s |=> !cmd_ready_o)
    else $error("ready stayed high after a command was taken");
  a_sleep_refusal: assert property (sleepy_recv_s |=> refused_s)
    else $error("receive in deep sleep not refused at once");
  a_frame_close_done: assert property ($rose(cs_b_o) |-> $past(done_o))
    else $error("chip select released without completion");
  a_shared_under_select: assert property (shared_data_line_oe_o |-> !cs_b_o)
    else $error("shared data line driven without chip select");
  a_read_beat_busy: assert property (rd_o.valid |-> !cmd_ready_o)
    else $error("read byte reported outside a command");
  a_spi_quiet_i2c: assert property (scl_oe_o || sda_oe_o |-> cs_b_o)
    else $error("chip select low during a two-wire transfer");
endmodule : serial_host_register_port_properties

bind serial_host_register_port serial_host_register_port_properties props (.clk_sys_i, .rst_b_i,
  .cmd_valid_i, .cmd_i, .cmd_ready_o, .deep_sleep_flag_i, .rd_o, .done_o, .nack_o, .cs_b_o,
  .sck_o, .mosi_o, .shared_data_line_oe_o, .scl_oe_o, .sda_oe_o);

// file: tb/serial_host_register_port_tb_top.sv
// Self-checking bench of the host controller against the behavioural device.
`timescale 1ns/1ps
module serial_host_register_port_tb_top;
  import host_pkg::*;
  logic       clk_sys_i = 1'b0, rst_b_i = 1'b0, cmd_valid_i = 1'b0, deep_sleep_flag_i = 1'b0;
  logic       wr_valid_i = 1'b0, cmd_ready_o, wr_ready_o, done_o, nack_o, cs_b_o, sck_o, mosi_o;
  logic       miso_i, shared_data_line_o, shared_data_line_oe_o, scl_o, scl_oe_o, sda_o;
  logic       sda_oe_o, sda_low, sda_dly, dev_shl, dev_shl_oe, saw_nack;
  logic [7:0] wr_data_i = 8'h00;
  cmd_t       cmd_i = '0;
  rd_beat_t   rd_o;
  int         n_mismatch = 0, check_count = 0, nclk = 0;
  logic [7:0] rxq [$];
  wire logic  scl_i = !scl_oe_o;
  wire logic  sda_i = !(sda_oe_o || sda_low);
  wire logic  three_wire = cmd_i.spi_3wire;
  // Both drivers at once shows as unknown; a released line rests high.
  wire logic  shared_data_line_i = shared_data_line_oe_o ? (dev_shl_oe ? 1'bx : shared_data_line_o)
                                                          : (dev_shl_oe ? dev_shl : 1'b1);
  assign #1 sda_dly = sda_i;

  serial_host_register_port dut (.clk_sys_i, .rst_b_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
    .deep_sleep_flag_i, .wr_valid_i, .wr_data_i, .wr_ready_o, .rd_o, .done_o, .nack_o, .cs_b_o,
    .sck_o, .mosi_o, .miso_i, .shared_data_line_i, .shared_data_line_o, .shared_data_line_oe_o,
    .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o);
  register_port_device dev (.cs_b_i(cs_b_o), .sck_i(sck_o), .mosi_i(mosi_o),
    .three_wire_i(three_wire), .shl_i(shared_data_line_i), .miso_o(miso_i), .shl_o(dev_shl),
    .shl_oe_o(dev_shl_oe), .scl_i(scl_i), .sda_i(sda_dly), .sda_low_o(sda_low));

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    if (rd_o.valid === 1'b1) rxq.push_back(rd_o.data);
    if (nack_o === 1'b1) saw_nack = 1'b1;
  end
  always @(posedge sck_o) if (!cs_b_o) nclk = nclk + 1;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic push_seq(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      wr_data_i <= b + 8'(i);
      wr_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      while (wr_ready_o !== 1'b1) @(posedge clk_sys_i);
    end
    wr_valid_i <= 1'b0;
  endtask : push_seq

  task automatic run(input op_t op, input logic [7:0] ra, input logic [7:0] n, input logic w3);
    int k;
    rxq.delete();
    saw_nack = 1'b0;
    nclk = 0;
    cmd_i <= '{op: op, spi_3wire: w3, dev_addr: 7'h28, reg_addr: ra, count: n};
    cmd_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    while (cmd_ready_o !== 1'b1) @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    for (k = 0; k < 30000 && done_o !== 1'b1; k++) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    chk({7'h00, k < 30000}, 8'h01, "command completion");
  endtask : run

  task automatic spi_pass(input logic w3);
    logic [7:0] b;
    b = w3 ? 8'hd0 : 8'hc0;
    push_seq(b, 3);
    run(OP_SPI_SETPTR, 8'hfe, 8'h00, w3);
    chk(8'(nclk), 8'h10, "set-pointer clocks");
    run(OP_SPI_WRITE, 8'h00, 8'h03, w3);
    chk(8'(nclk), 8'h20, "write clocks");
    for (int i = 0; i < 3; i++) chk(dev.regs[8'hfe + 8'(i)], b + 8'(i), "spi write");
    chk(dev.ptr, 8'h01, "spi pointer wrap");
    run(OP_SPI_SETPTR, 8'hfe, 8'h00, w3);
    run(OP_SPI_READ, 8'h00, 8'h03, w3);
    chk(8'(rxq.size()), 8'h03, "spi read count");
    for (int i = 0; i < rxq.size(); i++) chk(rxq[i], b + 8'(i), "spi read");
  endtask : spi_pass

  task automatic i2c_case();
    push_seq(8'h3c, 2);
    run(OP_BWRITE, 8'hff, 8'h02, 1'b0);
    chk({7'h00, saw_nack}, 8'h00, "block write acknowledged");
    chk({6'h00, scl_o, sda_o}, 8'h00, "open-drain drive level");
    chk(dev.regs[8'hff], 8'h3c, "block write first");
    chk(dev.regs[8'h00], 8'h3d, "block write wrapped");
    run(OP_BREAD, 8'hff, 8'h02, 1'b0);
    chk(8'(rxq.size()), 8'h02, "block read count");
    if (rxq.size() == 2) chk(rxq[1], 8'h3d, "block read wrapped");
    chk(dev.ptr, 8'h01, "pointer after block read");
    repeat (2) begin
      run(OP_RECV, 8'h00, 8'h00, 1'b0);
      chk(8'(rxq.size()), 8'h01, "receive count");
      if (rxq.size() == 1) chk(rxq[0], 8'h5b, "receive same register");
    end
    deep_sleep_flag_i <= 1'b1;
    run(OP_RECV, 8'h00, 8'h00, 1'b0);
    chk({7'h00, saw_nack}, 8'h01, "receive refused in sleep");
    chk(8'(rxq.size()), 8'h00, "no data in sleep");
    deep_sleep_flag_i <= 1'b0;
  endtask : i2c_case

  task automatic fifo_case();
    push_seq(8'h00, 32);
    @(posedge clk_sys_i);
    chk({7'h00, wr_ready_o}, 8'h00, "full buffer refuses");
    run(OP_SPI_SETPTR, 8'h80, 8'h00, 1'b0);
    run(OP_SPI_RESET, 8'h00, 8'h00, 1'b0);
    chk(dev.ptr, 8'h80, "interface reset keeps pointer");
    run(OP_SPI_WRITE, 8'h00, 8'h20, 1'b0);
    chk(dev.regs[8'h9f], 8'h1f, "last buffered byte");
    chk(dev.ptr, 8'ha0, "pointer after burst");
    chk({7'h00, wr_ready_o}, 8'h01, "drained buffer accepts");
  endtask : fifo_case

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  // The run needs some 45,000 cycles; twice that leaves room for slow stretches.
  initial begin
    #900us;
    n_mismatch = n_mismatch + 1;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    spi_pass(1'b0);
    spi_pass(1'b1);
    i2c_case();
    fifo_case();
    end_sim();
  end
endmodule : serial_host_register_port_tb_top
